// ---- logic/awpc_top.sv ----
/*
  Standby power and wake control: panel switch gating, keyboard/mouse/IR
  wake onto the power switch output, read-clear event flags, power-loss
  restart policy, power-good routing and upper port reset selection.
  Assumes classic Wishbone master, inputs synchronous to clk_i, and the
  separate battery, resume, power-good and bus resets as active-high pulses.
*/
// Behaviour
// - Wake bit 7 blocks panel switch
// - Wake bit 6 enables keyboard wake
// - Wake bit 5 enables mouse wake
// - Any-data set: any activity or click
// - Any-data clear: button and click count
// - Wake bit 3 enables infrared wake
// - Wake bit 2 swaps keyboard and mouse
// - Any-char bit or stored sequence wakes
// - Index maps key sets and incoming keys
// - Data register accesses indexed key location
// - Event status flags clear on read
// - Power-loss bits choose restart policy
// - Supply on waits for S3 high
// - Power-loss bit 3 selects any key
// - Hunt bit self-clears on wake event
// - Port reset selects resume or S5
// - Bit 2 lets reset connector gate
// - Bit 1 selects power-good source
// - Bit 0 removes supply power-good control
// - Socket bit mirrors occupied input
// - Case clear bit self-returns to zero
// - Power-loss bits have separate resets
// - Last-state flag: 0 on, 1 off
`timescale 1ns/1ps
module awpc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic battery_reset_i,
  input wire logic resume_reset_i,
  input wire logic power_good_reset_i,
  input wire logic bus_reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic panel_switch_input_i,
  input wire logic kb_key_valid_i,
  input wire logic [7:0] kb_key_i,
  input wire logic ms_left_click_i,
  input wire logic ms_right_click_i,
  input wire logic ms_move_i,
  input wire logic infrared_receiver_wake_i,
  input wire logic kb_port_clk_i,
  input wire logic ms_port_clk_i,
  input wire logic standby_supply_event_i,
  input wire logic thermal_shutdown_i,
  input wire logic sleep_s3_signal_i,
  input wire logic sleep_s5_signal_i,
  input wire logic pre_loss_state_on_i,
  input wire logic ac_return_i,
  input wire logic reset_connector_signal_n_i,
  input wire logic supply_power_good_input_i,
  input wire logic socket_occupied_input_i,
  output logic power_switch_output_n_o,
  output logic supply_on_output_n_o,
  output logic standby_switch_output_n_o,
  output logic power_good_output_o,
  output logic [2:0] port_reset_o,
  output logic kb_port_clk_o,
  output logic ms_port_clk_o,
  output logic case_intrusion0_clear_o
);
  logic [7:0] wake_control_reg;
  logic [7:0] kb_index_reg;
  logic [7:0] event_status_reg;
  logic [4:0] event_flags_reg;
  logic [7:0] power_loss_reg;
  logic [7:0] port_reset_src_reg;
  logic [7:0] mouse_case_reg;
  logic supply_on_req_reg;
  logic [7:0] idx;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  logic [7:0] key_rdata;
  logic key_match;
  logic ms_wake;
  logic kb_wake;
  logic ir_wake;
  logic any_wake;
  logic [7:0] wdata;
  logic pg_source;
  logic pg_next;

  // ==========================================================================
  // Wishbone slave: one-cycle ack, byte lane 0 carries the register
  assign idx = wb_adr_i[9:2];
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = access && wb_we_i && wb_sel_i[0];
  assign rd_en = access && !wb_we_i;
  assign wdata = wb_dat_i[7:0];

  always_comb begin
    case (idx)
      awpc_pkg::IDX_WAKE_CONTROL: rdata = wake_control_reg;
      awpc_pkg::IDX_KB_WAKE_INDEX: rdata = kb_index_reg;
      awpc_pkg::IDX_KB_WAKE_DATA: rdata = key_rdata;
      awpc_pkg::IDX_EVENT_STATUS: rdata = event_status_reg;
      awpc_pkg::IDX_POWER_LOSS: rdata = power_loss_reg;
      awpc_pkg::IDX_PORT_RESET_SRC: rdata = port_reset_src_reg;
      awpc_pkg::IDX_MOUSE_CASE: rdata = mouse_case_reg;
      default: rdata = awpc_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= rd_en ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Sub-blocks
  awpc_key_store u_keys (
    .clk_i(clk_i),
    .rst_i(rst_i || resume_reset_i),
    .index_i(kb_index_reg),
    .wr_i(wr_en && idx == awpc_pkg::IDX_KB_WAKE_DATA),
    .wdata_i(wdata),
    .rdata_o(key_rdata),
    .key_valid_i(kb_key_valid_i),
    .key_i(kb_key_i),
    .match_o(key_match)
  );

  awpc_mouse_detect u_mouse (
    .clk_i(clk_i),
    .rst_i(rst_i || resume_reset_i),
    .any_data_i(mouse_case_reg[awpc_pkg::MC_ANY_DATA]),
    .right_sel_i(wake_control_reg[awpc_pkg::WC_MS_RIGHT]),
    .any_sel_i(wake_control_reg[awpc_pkg::WC_MS_ANY]),
    .left_click_i(ms_left_click_i),
    .right_click_i(ms_right_click_i),
    .move_i(ms_move_i),
    .wake_o(ms_wake)
  );

  // ==========================================================================
  // Wake sources; either any-character bit allows any key
  assign kb_wake = wake_control_reg[awpc_pkg::WC_KB_WAKE_EN] &&
    ((kb_key_valid_i && (wake_control_reg[awpc_pkg::WC_KB_ANY_CHAR] ||
    power_loss_reg[awpc_pkg::PL_KB_ANY_KEY])) || key_match);
  assign ir_wake = wake_control_reg[awpc_pkg::WC_IR_WAKE_EN] && infrared_receiver_wake_i;
  assign any_wake = kb_wake || (wake_control_reg[awpc_pkg::WC_MS_WAKE_EN] && ms_wake) || ir_wake;

  // ==========================================================================
  // Control registers, battery backed or resume reset
  always_ff @(posedge clk_i) begin
    if (rst_i || battery_reset_i) begin
      wake_control_reg <= awpc_pkg::RST_WAKE_CONTROL;
    end else if (wr_en && idx == awpc_pkg::IDX_WAKE_CONTROL) begin
      wake_control_reg <= wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || resume_reset_i) begin
      kb_index_reg <= awpc_pkg::RST_ZERO;
    end else if (wr_en && idx == awpc_pkg::IDX_KB_WAKE_INDEX) begin
      kb_index_reg <= wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || resume_reset_i) begin
      port_reset_src_reg <= awpc_pkg::RST_PORT_RESET_SRC;
    end else if (wr_en && idx == awpc_pkg::IDX_PORT_RESET_SRC) begin
      port_reset_src_reg <= wdata & awpc_pkg::PR_MASK;
    end
  end

  // Per-field resets; hunt bit self-clears on any captured wake
  always_ff @(posedge clk_i) begin
    if (rst_i || battery_reset_i) begin
      power_loss_reg <= awpc_pkg::RST_ZERO;
    end else begin
      if (wr_en && idx == awpc_pkg::IDX_POWER_LOSS) begin
        power_loss_reg <= wdata & awpc_pkg::PL_MASK;
      end
      if (power_good_reset_i) begin
        power_loss_reg[awpc_pkg::PL_STANDBY_SW] <= 1'b0;
      end
      if (bus_reset_i) begin
        power_loss_reg[awpc_pkg::PL_KB_ANY_KEY] <= 1'b0;
        power_loss_reg[awpc_pkg::PL_HUNT] <= 1'b0;
      end else if (power_loss_reg[awpc_pkg::PL_HUNT] && any_wake) begin
        power_loss_reg[awpc_pkg::PL_HUNT] <= 1'b0;
      end
    end
  end

  // Socket bit is live, clear bit pulses for one cycle only
  always_ff @(posedge clk_i) begin
    if (rst_i || battery_reset_i) begin
      mouse_case_reg <= awpc_pkg::RST_MOUSE_CASE;
    end else begin
      if (resume_reset_i) begin
        mouse_case_reg[awpc_pkg::MC_ANY_DATA] <= awpc_pkg::RST_MOUSE_CASE[awpc_pkg::MC_ANY_DATA];
      end else if (wr_en && idx == awpc_pkg::IDX_MOUSE_CASE) begin
        mouse_case_reg[awpc_pkg::MC_ANY_DATA] <= wdata[awpc_pkg::MC_ANY_DATA];
        mouse_case_reg[awpc_pkg::MC_LAST_STATE] <= wdata[awpc_pkg::MC_LAST_STATE];
        mouse_case_reg[3:0] <= wdata[3:0];
      end
      mouse_case_reg[awpc_pkg::MC_SOCKET] <= socket_occupied_input_i;
      mouse_case_reg[awpc_pkg::MC_CASE0_CLR] <= wr_en && idx == awpc_pkg::IDX_MOUSE_CASE &&
        wdata[awpc_pkg::MC_CASE0_CLR] && !mouse_case_reg[awpc_pkg::MC_CASE0_CLR];
    end
  end

  // ==========================================================================
  // Event flags: set wins over the read clear
  generate
    for (genvar b = 0; b < 5; b++) begin : g_flags
      logic ev;
      always_comb begin
        case (b)
          awpc_pkg::ES_STANDBY: ev = standby_supply_event_i;
          awpc_pkg::ES_THERMAL: ev = thermal_shutdown_i;
          awpc_pkg::ES_PANEL: ev = panel_switch_input_i;
          awpc_pkg::ES_MOUSE: ev = ms_wake && wake_control_reg[awpc_pkg::WC_MS_WAKE_EN];
          default: ev = kb_wake;
        endcase
      end
      always_ff @(posedge clk_i) begin
        if (rst_i || battery_reset_i) begin
          event_flags_reg[b] <= 1'b0;
        end else if (ev) begin
          event_flags_reg[b] <= 1'b1;
        end else if (rd_en && idx == awpc_pkg::IDX_EVENT_STATUS) begin
          event_flags_reg[b] <= 1'b0;
        end
      end
    end
  endgenerate
  // Flags live in their own register so the reserved bits have a single driver
  assign event_status_reg = {3'h0, event_flags_reg};

  // ==========================================================================
  // Power switch: panel press or any enabled wake pulls it low, whether or not the hunt bit is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_switch_output_n_o <= 1'b1;
    end else begin
      power_switch_output_n_o <= !((panel_switch_input_i && !wake_control_reg[awpc_pkg::WC_PANEL_BLOCK]) ||
        (any_wake && power_loss_reg[awpc_pkg::PL_HUNT]) || any_wake);
    end
  end

  // Restart decision latched when AC returns; a power switch press asks for it too
  always_ff @(posedge clk_i) begin
    if (rst_i || battery_reset_i) begin
      supply_on_req_reg <= 1'b0;
    end else if (ac_return_i) begin
      case (power_loss_reg[awpc_pkg::PL_MODE_HI:awpc_pkg::PL_MODE_LO])
        awpc_pkg::PL_ON: supply_on_req_reg <= 1'b1;
        awpc_pkg::PL_PRESTATE: supply_on_req_reg <= pre_loss_state_on_i;
        awpc_pkg::PL_USER: supply_on_req_reg <= !mouse_case_reg[awpc_pkg::MC_LAST_STATE];
        default: supply_on_req_reg <= 1'b0;
      endcase
    end else if (!power_switch_output_n_o) begin
      supply_on_req_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_on_output_n_o <= 1'b1;
      standby_switch_output_n_o <= 1'b1;
    end else begin
      supply_on_output_n_o <= !(sleep_s3_signal_i && supply_on_req_reg);
      standby_switch_output_n_o <= !(power_loss_reg[awpc_pkg::PL_STANDBY_SW] && !sleep_s3_signal_i);
    end
  end

  // ==========================================================================
  // Power-good routing
  assign pg_source = port_reset_src_reg[awpc_pkg::PR_PG_FROM_S3] ? sleep_s3_signal_i :
    !supply_on_output_n_o;
  assign pg_next = pg_source &&
    (port_reset_src_reg[awpc_pkg::PR_PSU_PG_DIS] || supply_power_good_input_i) &&
    (!port_reset_src_reg[awpc_pkg::PR_RESETCON_EN] || reset_connector_signal_n_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_good_output_o <= 1'b0;
      port_reset_o <= 3'h7;
      kb_port_clk_o <= 1'b1;
      ms_port_clk_o <= 1'b1;
      case_intrusion0_clear_o <= 1'b0;
    end else begin
      power_good_output_o <= pg_next;
      port_reset_o[2] <= port_reset_src_reg[awpc_pkg::PR_PORT8] ? sleep_s5_signal_i : resume_reset_i;
      port_reset_o[1] <= port_reset_src_reg[awpc_pkg::PR_PORT7] ? sleep_s5_signal_i : resume_reset_i;
      port_reset_o[0] <= port_reset_src_reg[awpc_pkg::PR_PORT6] ? sleep_s5_signal_i : resume_reset_i;
      kb_port_clk_o <= wake_control_reg[awpc_pkg::WC_KBMS_SWAP] ? ms_port_clk_i : kb_port_clk_i;
      ms_port_clk_o <= wake_control_reg[awpc_pkg::WC_KBMS_SWAP] ? kb_port_clk_i : ms_port_clk_i;
      case_intrusion0_clear_o <= mouse_case_reg[awpc_pkg::MC_CASE0_CLR];
    end
  end

  // ==========================================================================
  // Checks
  hunt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    power_loss_reg[awpc_pkg::PL_HUNT] && any_wake && !wr_en |=> !power_loss_reg[awpc_pkg::PL_HUNT])
    else $error("hunt bit not cleared");
  flag_read_a: assert property (@(posedge clk_i) disable iff (rst_i || battery_reset_i)
    rd_en && idx == awpc_pkg::IDX_EVENT_STATUS && !thermal_shutdown_i |=> !event_status_reg[awpc_pkg::ES_THERMAL])
    else $error("status not cleared by read");
  flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i || battery_reset_i)
    event_status_reg[awpc_pkg::ES_PANEL] && !(rd_en && idx == awpc_pkg::IDX_EVENT_STATUS)
    |=> event_status_reg[awpc_pkg::ES_PANEL])
    else $error("status flag lost");
  panel_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    panel_switch_input_i && !wake_control_reg[awpc_pkg::WC_PANEL_BLOCK] |=> !power_switch_output_n_o)
    else $error("panel switch not passed");
  supply_s3_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !sleep_s3_signal_i |=> supply_on_output_n_o)
    else $error("supply on without S3");
  socket_a: assert property (@(posedge clk_i) disable iff (rst_i || battery_reset_i)
    ##1 mouse_case_reg[awpc_pkg::MC_SOCKET] == $past(socket_occupied_input_i))
    else $error("socket bit wrong");
  case_clear_a: assert property (@(posedge clk_i) disable iff (rst_i || battery_reset_i)
    mouse_case_reg[awpc_pkg::MC_CASE0_CLR] |=> !mouse_case_reg[awpc_pkg::MC_CASE0_CLR])
    else $error("case clear stuck");
  pg_psu_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_reset_src_reg[awpc_pkg::PR_PSU_PG_DIS] && !supply_power_good_input_i |=> !power_good_output_o)
    else $error("power good without supply");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

// ---- logic/awpc_pkg.sv ----
/*
  Package for the standby power and wake control block: register offsets,
  field positions, reset values and the mouse wake state encoding.
  Assumes byte-wide registers on a 32-bit classic Wishbone bus, one word each.
*/
package awpc_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_WAKE_CONTROL = 8'hE0;
  localparam logic [7:0] IDX_KB_WAKE_INDEX = 8'hE1;
  localparam logic [7:0] IDX_KB_WAKE_DATA = 8'hE2;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'hE3;
  localparam logic [7:0] IDX_POWER_LOSS = 8'hE4;
  localparam logic [7:0] IDX_PORT_RESET_SRC = 8'hE5;
  localparam logic [7:0] IDX_MOUSE_CASE = 8'hE6;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_WAKE_CONTROL = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PORT_RESET_SRC = 8'h02;
  localparam logic [7:0] RST_MOUSE_CASE = 8'h1A;
  // ==========================================================================
  // Wake control fields
  localparam int WC_PANEL_BLOCK = 7;
  localparam int WC_KB_WAKE_EN = 6;
  localparam int WC_MS_WAKE_EN = 5;
  localparam int WC_MS_RIGHT = 4;
  localparam int WC_IR_WAKE_EN = 3;
  localparam int WC_KBMS_SWAP = 2;
  localparam int WC_MS_ANY = 1;
  localparam int WC_KB_ANY_CHAR = 0;
  // Event status fields
  localparam int ES_STANDBY = 4;
  localparam int ES_THERMAL = 3;
  localparam int ES_PANEL = 2;
  localparam int ES_MOUSE = 1;
  localparam int ES_KEYBOARD = 0;
  localparam logic [7:0] ES_MASK = 8'h1F;
  // Power-loss fields
  localparam int PL_MODE_HI = 6;
  localparam int PL_MODE_LO = 5;
  localparam int PL_STANDBY_SW = 4;
  localparam int PL_KB_ANY_KEY = 3;
  localparam int PL_HUNT = 2;
  localparam logic [7:0] PL_MASK = 8'h7C;
  localparam logic [1:0] PL_OFF = 2'h0;
  localparam logic [1:0] PL_ON = 2'h1;
  localparam logic [1:0] PL_PRESTATE = 2'h2;
  localparam logic [1:0] PL_USER = 2'h3;
  // Port reset source fields
  localparam int PR_PORT8 = 5;
  localparam int PR_PORT7 = 4;
  localparam int PR_PORT6 = 3;
  localparam int PR_RESETCON_EN = 2;
  localparam int PR_PG_FROM_S3 = 1;
  localparam int PR_PSU_PG_DIS = 0;
  localparam logic [7:0] PR_MASK = 8'h3F;
  // Mouse / case / socket fields
  localparam int MC_ANY_DATA = 7;
  localparam int MC_SOCKET = 6;
  localparam int MC_CASE0_CLR = 5;
  localparam int MC_LAST_STATE = 4;
  // ==========================================================================
  // Key storage
  localparam int KEY_DEPTH = 128;
  localparam logic [7:0] KEY_SET1 = 8'h00;
  localparam logic [7:0] KEY_INCOMING = 8'h10;
  localparam logic [7:0] KEY_SET2 = 8'h30;
  localparam logic [7:0] KEY_SET3 = 8'h40;
  localparam logic [3:0] KEY_LAST = 4'hE;
  // ==========================================================================
  // Mouse click detector states
  typedef enum logic [2:0] {
    AWPC_MS_IDLE = 3'b001,
    AWPC_MS_ONE = 3'b010,
    AWPC_MS_WAKE = 3'b100
  } awpc_ms_state_t;
endpackage

// ---- logic/awpc_key_store.sv ----
/*
  Key-combination storage behind the index/data pair, with the incoming
  key recorder and the sequence matcher for wake key set one.
  Assumes one received key code per kb_key_valid_i pulse.
*/
`timescale 1ns/1ps
module awpc_key_store (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] index_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic key_valid_i,
  input wire logic [7:0] key_i,
  output logic match_o
);
  logic [7:0] mem [awpc_pkg::KEY_DEPTH];
  logic [3:0] rec_ptr_reg;
  logic [3:0] match_ptr_reg;
  logic [7:0] rec_addr;
  logic [7:0] set_addr;

  assign rec_addr = awpc_pkg::KEY_INCOMING + {4'h0, rec_ptr_reg};
  assign set_addr = awpc_pkg::KEY_SET1 + {4'h0, match_ptr_reg};
  // Data port sees the location chosen by the index
  assign rdata_o = mem[index_i[6:0]];
  assign match_o = key_valid_i && (key_i == mem[set_addr[6:0]]) && (match_ptr_reg == awpc_pkg::KEY_LAST);

  // ==========================================================================
  // Storage; a host write wins and the recorder skips its write that cycle
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[index_i[6:0]] <= wdata_i;
    end else if (key_valid_i) begin
      mem[rec_addr[6:0]] <= key_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_ptr_reg <= 4'h0;
    end else if (key_valid_i) begin
      rec_ptr_reg <= (rec_ptr_reg == awpc_pkg::KEY_LAST) ? 4'h0 : rec_ptr_reg + 4'h1;
    end
  end

  // Sequence must arrive in order; a wrong key restarts the search
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_ptr_reg <= 4'h0;
    end else if (key_valid_i) begin
      if (key_i != mem[set_addr[6:0]] || match_ptr_reg == awpc_pkg::KEY_LAST) begin
        match_ptr_reg <= 4'h0;
      end else begin
        match_ptr_reg <= match_ptr_reg + 4'h1;
      end
    end
  end
endmodule

// ---- logic/awpc_mouse_detect.sv ----
/*
  Mouse wake event detector: decodes the three select bits into one or
  two clicks of a chosen button, one click of either button, or any activity.
  Assumes click and move inputs are one-cycle pulses.
*/
`timescale 1ns/1ps
module awpc_mouse_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic any_data_i,
  input wire logic right_sel_i,
  input wire logic any_sel_i,
  input wire logic left_click_i,
  input wire logic right_click_i,
  input wire logic move_i,
  output logic wake_o
);
  awpc_pkg::awpc_ms_state_t state_reg;
  awpc_pkg::awpc_ms_state_t state_next;
  logic click;
  logic direct;

  assign click = right_sel_i ? right_click_i : left_click_i;
  always_comb begin
    if (any_data_i) begin
      direct = any_sel_i ? (left_click_i | right_click_i | move_i) : (left_click_i | right_click_i);
    end else begin
      direct = any_sel_i && click;
    end
  end

  // ==========================================================================
  // Two-click counter, used only with any-data clear and any-select clear
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      awpc_pkg::AWPC_MS_IDLE: begin
        if (direct) begin
          state_next = awpc_pkg::AWPC_MS_WAKE;
        end else if (!any_data_i && !any_sel_i && click) begin
          state_next = awpc_pkg::AWPC_MS_ONE;
        end
      end
      awpc_pkg::AWPC_MS_ONE: begin
        if (click) begin
          state_next = awpc_pkg::AWPC_MS_WAKE;
        end
      end
      awpc_pkg::AWPC_MS_WAKE: state_next = awpc_pkg::AWPC_MS_IDLE;
      default: state_next = awpc_pkg::AWPC_MS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= awpc_pkg::AWPC_MS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  assign wake_o = (state_reg == awpc_pkg::AWPC_MS_WAKE);
endmodule

// ---- sim/awpc_psu_model.sv ----
/*
  Supply model: power good follows the supply-on request after a lag.
  Assumes the block's active-low supply-on output.
*/
`timescale 1ns/1ps
module awpc_psu_model (
  input wire logic clk_i,
  input wire logic supply_on_n_i,
  output logic power_good_o
);
  // ==========================================
  // Good only after two requested cycles
  logic [1:0] lag_reg = 2'h0;
  always @(posedge clk_i) begin
    lag_reg <= supply_on_n_i ? 2'h0 : {lag_reg[0], 1'b1};
  end
  assign power_good_o = lag_reg[1];
endmodule

// ---- sim/acpi_wake_power_control_tb.sv ----
/*
  Bench for the wake and power control block, reads scored from a queue.
  Assumes word-spaced byte registers and a registered one-cycle ack.
*/
`timescale 1ns/1ps
module acpi_wake_power_control_tb;
  logic clk_i, rst_i, battery_reset_i, resume_reset_i, power_good_reset_i, bus_reset_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, panel_switch_input_i, kb_key_valid_i;
  logic ms_left_click_i, ms_right_click_i, ms_move_i, infrared_receiver_wake_i, kb_port_clk_i;
  logic ms_port_clk_i, standby_supply_event_i, thermal_shutdown_i, sleep_s3_signal_i, sleep_s5_signal_i;
  logic pre_loss_state_on_i, ac_return_i, reset_connector_signal_n_i, supply_power_good_input_i;
  logic socket_occupied_input_i, power_switch_output_n_o, supply_on_output_n_o, standby_switch_output_n_o;
  logic power_good_output_o, kb_port_clk_o, ms_port_clk_o, case_intrusion0_clear_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] kb_key_i, v, e;
  logic [2:0] port_reset_o;
  logic [7:0] exp_q[$];
  int fail_count = 0, comparisons = 0, cycles = 0, seed = 56, clears = 0;
  awpc_top uut (.*);
  awpc_psu_model psu (.clk_i(clk_i), .supply_on_n_i(supply_on_output_n_o), .power_good_o(supply_power_good_input_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ==========================================
  // Scoreboard and hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (case_intrusion0_clear_o === 1'b1) clears++;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      e = exp_q.pop_front();
      comparisons++;
      if (wb_dat_o !== {24'h00_0000, e}) begin
        fail_count++;
        $display("MISMATCH t=%0t read %h exp %h", $time, wb_dat_o, e);
      end
    end
  end
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    exp_q.push_back(x);
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic chk(input logic got, input logic x);
    comparisons++;
    if (got !== x) begin
      fail_count++;
      $display("MISMATCH t=%0t pin %b exp %b", $time, got, x);
    end
  endtask
  // AC return under one power-loss policy, supply checked once settled
  task automatic ac(input logic [7:0] pl, input logic x);
    bus(1'b1, 8'hE4, pl);
    ac_return_i <= 1'b1;
    @(posedge clk_i);
    ac_return_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(supply_on_output_n_o, x);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {battery_reset_i, resume_reset_i, power_good_reset_i, bus_reset_i, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {panel_switch_input_i, kb_key_valid_i, ms_left_click_i, ms_right_click_i, ms_move_i} = '0;
    {infrared_receiver_wake_i, standby_supply_event_i, thermal_shutdown_i, sleep_s3_signal_i, ac_return_i} = '0;
    {kb_port_clk_i, ms_port_clk_i, sleep_s5_signal_i, pre_loss_state_on_i, socket_occupied_input_i} = '0;
    {wb_adr_i, wb_dat_i, kb_key_i} = '0;
    reset_connector_signal_n_i = 1'b1;
    wb_sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    {kb_port_clk_i, ms_port_clk_i, pre_loss_state_on_i} <= 3'($random(seed));
    sleep_s5_signal_i <= 1'b1;
    socket_occupied_input_i <= 1'b1;
    rd(8'hE0, 8'h01);
    rd(8'hE3, 8'h00);
    rd(8'hE4, 8'h00);
    rd(8'hE5, 8'h02);
    rd(8'hE6, 8'h5A);
    rd(8'hE7, 8'h00);
    chk(port_reset_o == 3'h0, 1'b1);
    $display("done reset values");
    v = 8'($random(seed));
    bus(1'b1, 8'hE1, 8'h3E);
    bus(1'b1, 8'hE2, v);
    bus(1'b1, 8'hE1, 8'h00);
    bus(1'b1, 8'hE2, ~v);
    bus(1'b1, 8'hE1, 8'h3E);
    rd(8'hE2, v);
    $display("done key store");
    {thermal_shutdown_i, standby_supply_event_i} <= 2'b11;
    @(posedge clk_i);
    {thermal_shutdown_i, standby_supply_event_i} <= 2'b00;
    @(posedge clk_i);
    rd(8'hE3, 8'h18);
    rd(8'hE3, 8'h00);
    $display("done event flags");
    bus(1'b1, 8'hE0, 8'h41);
    bus(1'b1, 8'hE4, 8'h0C);
    kb_key_i <= v;
    kb_key_valid_i <= 1'b1;
    @(posedge clk_i);
    kb_key_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(8'hE3, 8'h01);
    rd(8'hE4, 8'h08);
    $display("done keyboard wake");
    kb_port_clk_i <= ~ms_port_clk_i;
    bus(1'b1, 8'hE0, 8'h26);
    chk(kb_port_clk_o, ms_port_clk_i);
    chk(ms_port_clk_o, kb_port_clk_i);
    ms_right_click_i <= 1'b1;
    @(posedge clk_i);
    ms_right_click_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(8'hE3, 8'h00);
    ms_left_click_i <= 1'b1;
    @(posedge clk_i);
    ms_left_click_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(8'hE3, 8'h02);
    $display("done mouse wake");
    bus(1'b1, 8'hE6, 8'h20);
    rd(8'hE6, 8'h40);
    chk(clears == 1, 1'b1);
    ac(8'h30, 1'b1);
    chk(standby_switch_output_n_o, 1'b0);
    power_good_reset_i <= 1'b1;
    @(posedge clk_i);
    power_good_reset_i <= 1'b0;
    rd(8'hE4, 8'h20);
    sleep_s3_signal_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(supply_on_output_n_o, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(power_good_output_o, 1'b1);
    reset_connector_signal_n_i <= 1'b0;
    bus(1'b1, 8'hE5, 8'h3C);
    chk(power_good_output_o, 1'b0);
    chk(port_reset_o == 3'h7, 1'b1);
    ac(8'h00, 1'b1);
    ac(8'h40, !pre_loss_state_on_i);
    ac(8'h60, 1'b0);
    $display("done power loss");
    panel_switch_input_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    panel_switch_input_i <= 1'b0;
    chk(power_switch_output_n_o, 1'b0);
    rd(8'hE3, 8'h04);
    $display("done panel switch");
    print_verdict();
  end
endmodule
